/* File: verilog/flptr_pkg.sv */
package flptr_pkg;

  localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h30;
  localparam logic [7:0] CMD_SOFT_RESET = 8'hF0;
  localparam logic [7:0] CMD_DYN_LOCK_READ = 8'hFA;
  localparam logic [7:0] CMD_DYN_LOCK_READ_WIDE = 8'hE0;
  localparam logic [7:0] CMD_DYN_LOCK_WRITE = 8'hFB;
  localparam logic [7:0] CMD_DYN_LOCK_WRITE_WIDE = 8'hE1;
  localparam logic [7:0] CMD_TRAINING_WRITE = 8'h4A;
  localparam logic [7:0] CMD_TRAINING_READ = 8'h41;
  localparam logic [7:0] CMD_OTP_PATTERN_PROGRAM = 8'h43;
  localparam logic [7:0] CMD_ONETIME_PROGRAM = 8'h42;
  localparam logic [7:0] CMD_ONETIME_READ = 8'h4B;
  localparam logic [7:0] CMD_ARRAY_PROGRAM = 8'h02;
  localparam logic [7:0] CMD_ARRAY_ERASE = 8'hD8;
  localparam logic [7:0] CMD_DDR_READ = 8'hEE;

  localparam logic [7:0] LOCK_ACCESS_PROTECTED = 8'h00;
  localparam logic [7:0] LOCK_ACCESS_UNPROTECTED = 8'hFF;
  localparam logic DYN_LOCK_RESET = 1'b1;
  localparam logic [7:0] OTP_PATTERN_RESET = 8'h00;
  localparam logic [7:0] OTP_ERASED_BYTE = 8'hFF;

  localparam int OTP_BYTES = 1024;
  localparam int OTP_ADDR_W = 10;
  localparam int REGION_ADDR_W = 5;
  localparam logic [9:0] LOCK_BYTE_BASE = 10'h010;
  localparam int LOCK_HALF_BIT = 4;
  localparam int ADDR_W = 24;
  localparam logic [1:0] ADDR_BYTES_NARROW = 2'h2;
  localparam logic [1:0] ADDR_BYTES_WIDE = 2'h3;
  localparam logic [2:0] DDR_LAST_EDGE = 3'h7;
  localparam logic [2:0] RANGE_ALL = 3'h7;
  localparam logic [2:0] BYTE_LAST_BIT = 3'h7;

  typedef enum logic [2:0] {
    ST_CMD,
    ST_ADDR,
    ST_DUMMY,
    ST_IN,
    ST_OUT,
    ST_IGNORE
  } flptr_state_t;

endpackage : flptr_pkg

/* File: verilog/flptr_otp_mem.sv */
module flptr_otp_mem import flptr_pkg::*; #(
  parameter int DEPTH = OTP_BYTES,
  parameter int AW = OTP_ADDR_W,
  parameter int DW = 8
) (
  input wire logic clk_i,
  input wire logic ce_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_a_i,
  output logic [DW-1:0] rdata_a_o,
  input wire logic [AW-1:0] raddr_b_i,
  output logic [DW-1:0] rdata_b_o
);

  logic [DW-1:0] mem [DEPTH];

  // Shipped erased; no erase path exists afterwards
  initial begin
    for (int i = 0; i < DEPTH; i++) begin
      mem[i] = OTP_ERASED_BYTE;
    end
  end

  // Plain always: the array is also preset by the initial block above
  always @(posedge clk_i) begin
    if (ce_i && we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      rdata_a_o <= mem[raddr_a_i];
      rdata_b_o <= mem[raddr_b_i];
    end
  end

endmodule : flptr_otp_mem

/* File: verilog/flptr_top.sv */
// Overview of operation
// - Per-sector dynamic lock bits are volatile only, reset to unprotected ones.
// - Dynamic lock byte 00h protects the addressed sector, FFh unprotects it.
// - Dynamic lock read FAh or E0h wide, write FBh or its wide variant.
// - OTP training pattern ships 00h, programs once, copies into volatile pattern.
// - Volatile training pattern writable anytime, reloaded from OTP pattern on reset.
// - DDR dummy edges drive the same pattern bit on all lines, MSB first.
// - Volatile pattern 00h means no preamble during DDR dummy phase.
// - Training write uses opcode 4Ah, training read uses opcode 41h.
// - 1024 byte OTP space in 32 independently locked 32 byte regions.
// - OTP read follows fast read; out-of-range data is indeterminate.
// - OTP program follows page program, repeatable, never erasable.
// - OTP program outside valid range silently ignored, no error flag.
// - OTP program in range while frozen fails and sets error flag.
// - Protection scheme mode never guards OTP; only freeze and lock bits do.
// - Lock bit per region, LSB lowest; bit 0 guards upper half of region 0.
// - Write enable command sets the latch before non-volatile changes.
// - Latch clears at reset and after completing write-class commands.
// - Select 0: range code protects 0, 1/64 up to all from the top.
// - Select 1: same fractions counted from the lowest address.
// - Range code sets size, top/bottom select sets starting end.
// - Sector protected if range protection or sector scheme protects it.
// - Freeze locks range controls and OTP space until the next RESET_N_I reset.
// - Sector protected when persistent or dynamic lock bit is zero.
// - Dynamic lock bit matters only where persistent lock bit is one.
// - Program error flag reported as status bit six.
module flptr_top import flptr_pkg::*; #(
  parameter int SECT_BITS = 6
) (
  input wire logic CLK_SYS_I,
  input wire logic RESET_N_I,
  input wire logic CE_I,
  input wire logic SCK_I,
  input wire logic CS_N_I,
  input wire logic SI_I,
  input wire logic FREEZE_I,
  input wire logic [2:0] RANGE_SIZE_I,
  input wire logic RANGE_TOP_BOTTOM_I,
  input wire logic [(1<<SECT_BITS)-1:0] PERSIST_LOCK_I,
  output logic [3:0] DATA_O,
  output logic [3:0] DATA_OE_O,
  output logic [7:0] STATUS_O,
  output logic ARRAY_PROG_O,
  output logic ARRAY_ERASE_O,
  output logic [ADDR_W-1:0] ARRAY_ADDR_O,
  output logic [7:0] ARRAY_DATA_O
);

  localparam int SECTORS = 1 << SECT_BITS;
  localparam int SYNC_W = SECTORS + 8;
  localparam logic [SYNC_W-1:0] SYNC_RST = {1'b0, 1'b1, 6'h00, {SECTORS{1'b1}}};
  localparam logic [SECT_BITS:0] SECT_TOTAL = (SECT_BITS + 1)'(SECTORS);

  logic [1:0] rst_sr;
  logic rst_n;
  logic [SYNC_W-1:0] sync1_reg, sync2_reg;
  logic sck_prev_reg, cs_prev_reg;
  flptr_state_t state_reg, state_next;
  logic [7:0] cmd_reg;
  logic [2:0] bit_cnt_reg;
  logic [6:0] rx_sr_reg;
  logic [31:0] addr_reg;
  logic [1:0] addr_left_reg;
  logic [2:0] ddr_idx_reg;
  logic first_reg;
  logic wel_reg, err_reg, frozen_reg, vpat_load_reg;
  logic [SECTORS-1:0] dyb_reg;
  logic [7:0] vpat_reg;
  // One-time pattern is non-volatile, kept outside the reset so a reset cannot reopen it
  logic [7:0] opat_reg = OTP_PATTERN_RESET;
  logic opat_done_reg = 1'b0;
  logic [2:0] range_reg;
  logic tb_reg;
  logic [3:0] data_reg, oe_reg;
  logic aprog_reg, aerase_reg;
  logic [ADDR_W-1:0] aaddr_reg;
  logic [7:0] adata_reg;
  logic [7:0] otp_rdata, lock_rdata;

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rst_sr <= 2'h0;
    end else if (CE_I) begin
      rst_sr <= {rst_sr[0], 1'b1};
    end
  end
  assign rst_n = rst_sr[1];

  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= SYNC_RST;
      sync2_reg <= SYNC_RST;
      sck_prev_reg <= 1'b0;
      cs_prev_reg <= 1'b1;
    end else if (CE_I) begin
      sync1_reg <= {SCK_I, CS_N_I, SI_I, FREEZE_I, RANGE_SIZE_I, RANGE_TOP_BOTTOM_I, PERSIST_LOCK_I};
      sync2_reg <= sync1_reg;
      sck_prev_reg <= sync2_reg[SYNC_W-1];
      cs_prev_reg <= sync2_reg[SYNC_W-2];
    end
  end

  wire sck_s = sync2_reg[SYNC_W-1];
  wire cs_n_s = sync2_reg[SYNC_W-2];
  wire si_s = sync2_reg[SYNC_W-3];
  wire freeze_s = sync2_reg[SYNC_W-4];
  wire [2:0] range_s = sync2_reg[SYNC_W-5 -: 3];
  wire tb_s = sync2_reg[SECTORS];
  wire [SECTORS-1:0] ppb_s = sync2_reg[SECTORS-1:0];

  wire active = ~cs_n_s;
  wire sck_rise = active & sck_s & ~sck_prev_reg;
  wire sck_fall = active & ~sck_s & sck_prev_reg;
  wire cs_rise = cs_n_s & ~cs_prev_reg;
  wire [7:0] rx_byte = {rx_sr_reg, si_s};
  wire byte_done = sck_rise & (bit_cnt_reg == BYTE_LAST_BIT);
  wire cmd_done = byte_done & (state_reg == ST_CMD);
  wire addr_done = byte_done & (state_reg == ST_ADDR) & (addr_left_reg == 2'h0);
  wire in_done = byte_done & (state_reg == ST_IN);

  wire is_dyn_read = (cmd_reg == CMD_DYN_LOCK_READ) | (cmd_reg == CMD_DYN_LOCK_READ_WIDE);
  wire is_dyn_write = (cmd_reg == CMD_DYN_LOCK_WRITE) | (cmd_reg == CMD_DYN_LOCK_WRITE_WIDE);
  wire is_ddr = cmd_reg == CMD_DDR_READ;
  wire rx_wide = (rx_byte == CMD_DYN_LOCK_READ_WIDE) | (rx_byte == CMD_DYN_LOCK_WRITE_WIDE);
  wire rx_has_addr = (rx_byte == CMD_DYN_LOCK_READ) | (rx_byte == CMD_DYN_LOCK_WRITE) | rx_wide
    | (rx_byte == CMD_ONETIME_PROGRAM) | (rx_byte == CMD_ONETIME_READ) | (rx_byte == CMD_ARRAY_PROGRAM)
    | (rx_byte == CMD_ARRAY_ERASE) | (rx_byte == CMD_DDR_READ);
  wire write_class = (cmd_reg == CMD_ONETIME_PROGRAM) | (cmd_reg == CMD_OTP_PATTERN_PROGRAM)
    | (cmd_reg == CMD_ARRAY_PROGRAM) | (cmd_reg == CMD_ARRAY_ERASE);

  // Sector index from the low 24 address bits, also for the wide forms
  wire [SECT_BITS-1:0] sector = addr_reg[ADDR_W-1 -: SECT_BITS];
  wire [SECT_BITS:0] span = (range_reg == 3'h0) ? '0 : (SECT_TOTAL >> (RANGE_ALL - range_reg));
  wire in_top = {1'b0, sector} >= (SECT_TOTAL - span);
  wire in_bottom = {1'b0, sector} < span;
  wire range_hit = tb_reg ? in_bottom : in_top;
  wire scheme_hit = ~ppb_s[sector] | ~dyb_reg[sector];
  wire sector_protected = range_hit | scheme_hit;

  wire [OTP_ADDR_W-1:0] otp_addr = addr_reg[OTP_ADDR_W-1:0];
  wire otp_valid = addr_reg[ADDR_W-1:OTP_ADDR_W] == '0;
  wire [OTP_ADDR_W-1:0] lock_addr = LOCK_BYTE_BASE | {8'h00, otp_addr[9:8]};
  wire lower_half_zero = (otp_addr[9:5] == 5'h00) & ~otp_addr[LOCK_HALF_BIT];
  wire otp_locked = ~lock_rdata[otp_addr[7:5]] & ~lower_half_zero;
  wire otp_try = in_done & (cmd_reg == CMD_ONETIME_PROGRAM) & wel_reg;
  // Only freeze and lock bits decide; the sector scheme is not consulted here
  wire otp_fail = otp_try & otp_valid & (frozen_reg | otp_locked);
  wire otp_we = otp_try & otp_valid & ~frozen_reg & ~otp_locked;
  // Program only clears bits, so repeated programs of one byte accumulate
  wire [7:0] otp_wdata = otp_rdata & rx_byte;
  wire pat_try = in_done & first_reg & (cmd_reg == CMD_OTP_PATTERN_PROGRAM) & wel_reg;
  wire pat_ok = pat_try & ~opat_done_reg;
  wire arr_try = in_done & (cmd_reg == CMD_ARRAY_PROGRAM) & wel_reg;
  wire ers_try = cs_rise & (cmd_reg == CMD_ARRAY_ERASE) & (state_reg == ST_IGNORE) & wel_reg;
  wire arr_fail = (arr_try | ers_try) & sector_protected;
  wire err_set = otp_fail | (pat_try & opat_done_reg) | arr_fail;
  wire err_clr = cmd_done & (rx_byte == CMD_CLEAR_STATUS);
  wire soft_rst = cmd_done & (rx_byte == CMD_SOFT_RESET);
  wire ddr_edge = (state_reg == ST_DUMMY) & is_ddr & (sck_rise | sck_fall);

  logic [7:0] tx_byte;
  assign tx_byte = (cmd_reg == CMD_TRAINING_READ) ? vpat_reg
    : is_dyn_read ? (dyb_reg[sector] ? LOCK_ACCESS_UNPROTECTED : LOCK_ACCESS_PROTECTED)
    : otp_rdata;

  flptr_otp_mem u_otp (
    .clk_i(CLK_SYS_I),
    .ce_i(CE_I),
    .we_i(otp_we),
    .waddr_i(otp_addr),
    .wdata_i(otp_wdata),
    .raddr_a_i(otp_addr),
    .rdata_a_o(otp_rdata),
    .raddr_b_i(lock_addr),
    .rdata_b_o(lock_rdata)
  );

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_CMD: begin
        if (cmd_done) begin
          if (rx_has_addr) begin
            state_next = ST_ADDR;
          end else if (rx_byte == CMD_TRAINING_READ) begin
            state_next = ST_OUT;
          end else if ((rx_byte == CMD_TRAINING_WRITE) || (rx_byte == CMD_OTP_PATTERN_PROGRAM)) begin
            state_next = ST_IN;
          end else begin
            state_next = ST_IGNORE;
          end
        end
      end
      ST_ADDR: begin
        if (addr_done) begin
          if ((cmd_reg == CMD_ONETIME_READ) || is_ddr) begin
            state_next = ST_DUMMY;
          end else if (is_dyn_read) begin
            state_next = ST_OUT;
          end else if (is_dyn_write || (cmd_reg == CMD_ONETIME_PROGRAM) || (cmd_reg == CMD_ARRAY_PROGRAM)) begin
            state_next = ST_IN;
          end else begin
            state_next = ST_IGNORE;
          end
        end
      end
      ST_DUMMY: begin
        if (is_ddr && ddr_edge && (ddr_idx_reg == DDR_LAST_EDGE)) begin
          state_next = ST_IGNORE;
        end else if (!is_ddr && byte_done) begin
          state_next = ST_OUT;
        end
      end
      default: begin
        state_next = state_reg;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_CMD;
      bit_cnt_reg <= 3'h0;
      rx_sr_reg <= 7'h00;
      cmd_reg <= 8'h00;
      first_reg <= 1'b0;
    end else if (CE_I) begin
      if (!active) begin
        state_reg <= ST_CMD;
        bit_cnt_reg <= 3'h0;
      end else begin
        state_reg <= state_next;
        if (sck_rise) begin
          bit_cnt_reg <= bit_cnt_reg + 3'h1;
          rx_sr_reg <= rx_byte[6:0];
        end
      end
      if (cmd_done) begin
        cmd_reg <= rx_byte;
      end
      if (cmd_done || addr_done) begin
        first_reg <= 1'b1;
      end else if (in_done) begin
        first_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      addr_reg <= 32'h0;
      addr_left_reg <= 2'h0;
    end else if (CE_I) begin
      if (cmd_done) begin
        addr_reg <= 32'h0;
        addr_left_reg <= rx_wide ? ADDR_BYTES_WIDE : ADDR_BYTES_NARROW;
      end else if (byte_done && (state_reg == ST_ADDR)) begin
        addr_reg <= {addr_reg[23:0], rx_byte};
        addr_left_reg <= addr_left_reg - 2'h1;
      end else if ((in_done && !is_dyn_write) || (byte_done && (state_reg == ST_OUT))) begin
        addr_reg <= addr_reg + 32'h1;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      wel_reg <= 1'b0;
      err_reg <= 1'b0;
      frozen_reg <= 1'b0;
      range_reg <= 3'h0;
      tb_reg <= 1'b0;
    end else if (CE_I) begin
      if (cmd_done && (rx_byte == CMD_WRITE_ENABLE)) begin
        wel_reg <= 1'b1;
      end else if (soft_rst || (cmd_done && (rx_byte == CMD_WRITE_DISABLE)) || (cs_rise && write_class)) begin
        wel_reg <= 1'b0;
      end
      if (err_set) begin
        err_reg <= 1'b1;
      end else if (err_clr) begin
        err_reg <= 1'b0;
      end
      if (freeze_s) begin
        frozen_reg <= 1'b1;
      end
      if (!frozen_reg) begin
        range_reg <= range_s;
        tb_reg <= tb_s;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      dyb_reg <= {SECTORS{DYN_LOCK_RESET}};
      vpat_reg <= OTP_PATTERN_RESET;
      vpat_load_reg <= 1'b1;
    end else if (CE_I) begin
      vpat_load_reg <= 1'b0;
      if (in_done && first_reg && is_dyn_write) begin
        if (rx_byte == LOCK_ACCESS_PROTECTED) begin
          dyb_reg[sector] <= 1'b0;
        end else if (rx_byte == LOCK_ACCESS_UNPROTECTED) begin
          dyb_reg[sector] <= 1'b1;
        end
      end
      if (pat_ok) begin
        vpat_reg <= rx_byte;
      end else if (soft_rst || vpat_load_reg) begin
        // Reload in the first cycle after reset, keeping the reset branch constant
        vpat_reg <= opat_reg;
      end else if (in_done && first_reg && (cmd_reg == CMD_TRAINING_WRITE)) begin
        vpat_reg <= rx_byte;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (CE_I && pat_ok) begin
      opat_reg <= rx_byte;
      opat_done_reg <= 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      data_reg <= 4'h0;
      oe_reg <= 4'h0;
      ddr_idx_reg <= 3'h0;
    end else if (CE_I) begin
      if (!active) begin
        oe_reg <= 4'h0;
        ddr_idx_reg <= 3'h0;
      end else if (ddr_edge) begin
        data_reg <= {4{vpat_reg[~ddr_idx_reg]}};
        oe_reg <= {4{vpat_reg != 8'h00}};
        ddr_idx_reg <= ddr_idx_reg + 3'h1;
      end else if (sck_fall && (state_reg == ST_OUT)) begin
        data_reg <= {2'b00, tx_byte[~bit_cnt_reg], 1'b0};
        oe_reg <= 4'b0010;
      end else if (sck_fall) begin
        oe_reg <= 4'h0;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      aprog_reg <= 1'b0;
      aerase_reg <= 1'b0;
      aaddr_reg <= '0;
      adata_reg <= 8'h00;
    end else if (CE_I) begin
      aprog_reg <= arr_try & ~sector_protected;
      aerase_reg <= ers_try & ~sector_protected;
      if (arr_try || ers_try) begin
        aaddr_reg <= addr_reg[ADDR_W-1:0];
        adata_reg <= rx_byte;
      end
    end
  end

  assign DATA_O = data_reg;
  assign DATA_OE_O = oe_reg;
  assign STATUS_O = {1'b0, err_reg, 4'h0, wel_reg, 1'b0};
  assign ARRAY_PROG_O = aprog_reg;
  assign ARRAY_ERASE_O = aerase_reg;
  assign ARRAY_ADDR_O = aaddr_reg;
  assign ARRAY_DATA_O = adata_reg;

  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!rst_n);

  sequence s_dyn_clear;
    CE_I && in_done && first_reg && is_dyn_write && (rx_byte == LOCK_ACCESS_PROTECTED);
  endsequence
  sequence s_ddr_edge_on;
    CE_I && ddr_edge && (vpat_reg != 8'h00);
  endsequence
  sequence s_write_done;
    CE_I && cs_rise && write_class && !(cmd_done);
  endsequence

  a_dyb_reset_ones: assert property ($rose(rst_n) |-> dyb_reg == {SECTORS{1'b1}})
    else $error("dynamic locks not unprotected after reset");
  a_dyb_write_clear: assert property (s_dyn_clear |=> !dyb_reg[$past(sector)])
    else $error("dynamic lock not cleared by 00h");
  a_pattern_copy_vol: assert property (CE_I && pat_ok |=> (vpat_reg == $past(rx_byte)) && opat_done_reg)
    else $error("pattern program did not copy to volatile");
  a_pattern_once_only: assert property (CE_I && pat_try && opat_done_reg |=> $stable(opat_reg) && err_reg)
    else $error("one-time pattern reprogrammed");
  a_ddr_pattern_bit: assert property (s_ddr_edge_on |=> DATA_O == {4{vpat_reg[~$past(ddr_idx_reg)]}})
    else $error("wrong training bit on data lines");
  a_ddr_no_preamble: assert property (CE_I && ddr_edge && (vpat_reg == 8'h00) |=> DATA_OE_O == 4'h0)
    else $error("preamble driven with zero pattern");
  a_otp_range_quiet: assert property (otp_try && !otp_valid && !err_reg && !err_clr |-> !otp_we ##1 !err_reg)
    else $error("out-of-range program had an effect");
  a_otp_freeze_err: assert property (CE_I && otp_try && otp_valid && frozen_reg |-> !otp_we ##1 STATUS_O[6])
    else $error("frozen program did not flag error");
  a_wel_clear_done: assert property (s_write_done |=> !STATUS_O[1])
    else $error("write enable latch not cleared");
  a_protect_no_prog: assert property (CE_I && arr_try && sector_protected |=> !ARRAY_PROG_O ##1 !ARRAY_PROG_O)
    else $error("protected sector programmed");

endmodule : flptr_top

/* File: bench/flptr_host.sv */
module flptr_host (
  input wire logic clk_i,
  input wire logic [3:0] data_i,
  input wire logic [3:0] oe_i,
  output logic sck_o,
  output logic cs_n_o,
  output logic si_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Eight system clocks per half period leaves margin over the two-flop pin sync
  localparam int HALF = 8;
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
  end
  task automatic hold();
    repeat (HALF) @(negedge clk_i);
  endtask : hold
  task automatic start();
    @(negedge clk_i);
    cs_n_o = 1'b0;
    hold();
  endtask : start
  task automatic stop();
    sck_o = 1'b0;
    hold();
    cs_n_o = 1'b1;
    // Deselected line flips so stale data never looks valid
    si_o = ~si_o;
    hold();
  endtask : stop
  task automatic xb(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      sck_o = 1'b0;
      si_o = b[i];
      hold();
      r[i] = data_i[1];
      sck_o = 1'b1;
      hold();
    end
  endtask : xb
  task automatic ddr(output logic [31:0] d, output logic [3:0] oe);
    oe = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      sck_o = ~sck_o;
      hold();
      d[4*i+:4] = data_i;
      oe = oe | oe_i;
    end
  endtask : ddr
endmodule : flptr_host

/* File: bench/tb.sv */
module tb import flptr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] zb = 8'h00;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic freeze = 1'b0;
  logic tbsel = 1'b0;
  logic [2:0] rng = 3'h0;
  logic [63:0] plock = '1;
  logic sck, cs_n, si, aprog, aerase;
  logic [3:0] dq, dq_oe, doe;
  logic [7:0] status, adata, r, last_data;
  logic [23:0] aaddr, last_addr;
  logic [31:0] dd;
  logic [5:0] s;
  int n_errors = 0, cmp_count = 0, n_prog = 0, n_erase = 0, n, e0;
  logic p;
  always #50 clk = ~clk;
  flptr_top i_flptr_top (.CLK_SYS_I(clk), .RESET_N_I(rst_n), .CE_I(1'b1), .SCK_I(sck), .CS_N_I(cs_n),
    .SI_I(si), .FREEZE_I(freeze), .RANGE_SIZE_I(rng), .RANGE_TOP_BOTTOM_I(tbsel), .PERSIST_LOCK_I(plock),
    .DATA_O(dq), .DATA_OE_O(dq_oe), .STATUS_O(status), .ARRAY_PROG_O(aprog), .ARRAY_ERASE_O(aerase),
    .ARRAY_ADDR_O(aaddr), .ARRAY_DATA_O(adata));
  flptr_host i_flptr_host (.clk_i(clk), .data_i(dq), .oe_i(dq_oe), .sck_o(sck), .cs_n_o(cs_n), .si_o(si));
  always @(posedge clk) begin
    if (aprog === 1'b1) begin
      n_prog++;
      last_addr = aaddr;
      last_data = adata;
    end
    if (aerase === 1'b1) n_erase++;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic cmd(input logic [7:0] q[$]);
    i_flptr_host.start();
    foreach (q[i]) i_flptr_host.xb(q[i], r);
    i_flptr_host.stop();
  endtask : cmd
  task automatic wcmd(input logic [7:0] q[$]);
    cmd('{CMD_WRITE_ENABLE});
    cmd(q);
  endtask : wcmd
  task automatic ddr_frame();
    i_flptr_host.start();
    i_flptr_host.xb(CMD_DDR_READ, r);
    repeat (3) i_flptr_host.xb(zb, r);
    i_flptr_host.ddr(dd, doe);
    i_flptr_host.stop();
  endtask : ddr_frame
  task automatic summarize();
    $display("errors=%0d compares=%0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  initial begin
    #9000000;
    n_errors++;
    summarize();
  end
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (10) @(negedge clk);
    check(status, 8'h00);
    cmd('{CMD_DYN_LOCK_READ, 8'h14, zb, zb, zb});
    check(r, LOCK_ACCESS_UNPROTECTED);
    cmd('{CMD_DYN_LOCK_WRITE, 8'h14, zb, zb, LOCK_ACCESS_PROTECTED});
    cmd('{CMD_DYN_LOCK_READ_WIDE, zb, 8'h14, zb, zb, zb});
    check(r, 8'h00);
    e0 = n_prog;
    wcmd('{CMD_ARRAY_PROGRAM, 8'h14, zb, 8'h10, 8'h5A});
    check(n_prog - e0, 0);
    check(status, 8'h40);
    cmd('{CMD_CLEAR_STATUS});
    cmd('{CMD_DYN_LOCK_WRITE_WIDE, zb, 8'h14, zb, zb, LOCK_ACCESS_UNPROTECTED});
    plock[5] = 1'b0;
    wcmd('{CMD_ARRAY_PROGRAM, 8'h14, zb, 8'h10, 8'h5A});
    check(n_prog - e0, 0);
    plock = '1;
    cmd('{CMD_ARRAY_PROGRAM, 8'h14, zb, 8'h10, 8'h5A});
    check(n_prog - e0, 0);
    cmd('{CMD_CLEAR_STATUS});
    wcmd('{CMD_ARRAY_PROGRAM, 8'h14, zb, 8'h10, 8'h5A});
    check(n_prog - e0, 1);
    check({last_addr, last_data}, 32'h1400105A);
    cmd('{CMD_WRITE_ENABLE});
    check(status, 8'h02);
    cmd('{CMD_WRITE_DISABLE});
    check(status, 8'h00);
    cmd('{CMD_TRAINING_READ, zb});
    check(r, OTP_PATTERN_RESET);
    ddr_frame();
    check(doe, 4'h0);
    cmd('{CMD_TRAINING_WRITE, 8'h34});
    cmd('{CMD_TRAINING_READ, zb});
    check(r, 8'h34);
    ddr_frame();
    check(dd, 32'h00FF0F00);
    check(doe, 4'hF);
    wcmd('{CMD_OTP_PATTERN_PROGRAM, 8'hC3});
    cmd('{CMD_TRAINING_READ, zb});
    check(r, 8'hC3);
    cmd('{CMD_TRAINING_WRITE, 8'h11});
    cmd('{CMD_SOFT_RESET});
    cmd('{CMD_TRAINING_READ, zb});
    check(r, 8'hC3);
    wcmd('{CMD_OTP_PATTERN_PROGRAM, 8'h5A});
    check(status, 8'h40);
    cmd('{CMD_CLEAR_STATUS});
    wcmd('{CMD_ONETIME_PROGRAM, zb, zb, 8'h20, 8'hA5});
    check(status, 8'h00);
    wcmd('{CMD_ONETIME_PROGRAM, zb, zb, 8'h20, 8'h0F});
    cmd('{CMD_ONETIME_READ, zb, zb, 8'h20, zb, zb});
    check(r, 8'h05);
    wcmd('{CMD_ONETIME_PROGRAM, zb, zb, 8'h10, 8'hFE});
    wcmd('{CMD_ONETIME_PROGRAM, zb, zb, 8'h14, zb});
    check(status, 8'h40);
    cmd('{CMD_CLEAR_STATUS});
    wcmd('{CMD_ONETIME_PROGRAM, zb, zb, 8'h0F, 8'h3C});
    wcmd('{CMD_ONETIME_PROGRAM, zb, zb, 8'h21, 8'h3C});
    cmd('{CMD_ONETIME_READ, zb, zb, 8'h1F, zb, zb, zb, zb});
    check({r, status}, 16'h3C00);
    plock = '0;
    wcmd('{CMD_ONETIME_PROGRAM, zb, zb, 8'h40, 8'h3C});
    cmd('{CMD_ONETIME_READ, zb, zb, 8'h40, zb, zb});
    check({r, status}, 16'h3C00);
    plock = '1;
    for (int c = 0; c < 8; c++) begin
      for (int t = 0; t < 2; t++) begin
        n = (c == 0) ? 0 : (1 << (c - 1));
        rng = c[2:0];
        tbsel = t[0];
        for (int k = 0; k < 2; k++) begin
          s = 6'(t ? n - k : 63 - n + k);
          p = t ? (int'(s) < n) : (int'(s) >= 64 - n);
          e0 = n_erase;
          wcmd('{CMD_ARRAY_ERASE, {s, 2'b00}, zb, zb});
          check(n_erase - e0, 32'(!p));
        end
      end
    end
    rng = 3'h0;
    tbsel = 1'b0;
    cmd('{CMD_CLEAR_STATUS});
    freeze = 1'b1;
    repeat (6) @(negedge clk);
    rng = 3'h7;
    e0 = n_erase;
    wcmd('{CMD_ARRAY_ERASE, 8'hFC, zb, zb});
    check(n_erase - e0, 1);
    wcmd('{CMD_ONETIME_PROGRAM, zb, 8'h04, zb, zb});
    check(status, 8'h00);
    wcmd('{CMD_ONETIME_PROGRAM, zb, zb, 8'h60, zb});
    check(status, 8'h40);
    rst_n = 1'b0;
    freeze = 1'b0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (10) @(negedge clk);
    check(status, 8'h00);
    e0 = n_erase;
    wcmd('{CMD_ARRAY_ERASE, 8'hFC, zb, zb});
    check(n_erase - e0, 0);
    cmd('{CMD_TRAINING_READ, zb});
    check(r, 8'hC3);
    summarize();
  end
endmodule : tb
